// ===== rtl/nvb_pkg.sv
/*
 * Constants shared by the block-write command logic: command and status codes,
 * memory geometry, checksum polynomial and programming time.
 * Assumes a 100 MHz system clock.
 */
package nvb_pkg;

	// ************************************************************
	// Memory geometry
	// ************************************************************
	localparam int        NUM_BLOCKS   = 31;
	localparam int        BLOCK_BYTES  = 8;
	localparam logic [4:0] LAST_BLOCK  = 5'h1E;
	localparam logic [3:0] MAX_WRITES  = 4'h8;

	// ************************************************************
	// Command and completion-status codes
	// ************************************************************
	localparam logic [7:0] CMD_WRITE_BLOCK = 8'h55;
	localparam logic [7:0] CS_PROTECTED    = 8'h55;
	localparam logic [7:0] CS_EXHAUSTED    = 8'h33;
	localparam logic [7:0] CS_FAULT        = 8'hEE;
	localparam logic [3:0] CS_OK_NIBBLE    = 4'hA;

	// ************************************************************
	// Checksum, reflected form for lowest-bit-first shifting
	// ************************************************************
	localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
	localparam logic [15:0] CRC_CLEAR     = 16'h0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_PROG_US     = 10;
	localparam int PROG_CYCLES   = (T_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TX_FIFO_DEPTH = 16;

	// ************************************************************
	// Command states, Gray coded in declaration order
	// ************************************************************
	typedef enum logic [2:0] {
		NVB_IDLE    = 3'b000,
		NVB_PARAM   = 3'b001,
		NVB_CRC_TX  = 3'b011,
		NVB_DATA    = 3'b010,
		NVB_RELEASE = 3'b110,
		NVB_PROG    = 3'b111,
		NVB_STATUS  = 3'b101,
		NVB_HALT    = 3'b100
	} nvb_state_t;

	function automatic logic [15:0] nvb_crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ b[i]) begin
				c = (c >> 1) ^ CRC_POLY_REFL;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction : nvb_crc_byte

endpackage : nvb_pkg

// ===== rtl/nvb_block_write.sv
/*
 * Block-write command interpreter of a single-contact serial memory, with its
 * transmit FIFO. Holds the user memory, protection bits and write counters.
 * Assumes a link layer on the same clock that delivers received bytes as
 * one-cycle strobes, signals bus reset pulses, and drains transmit bytes
 * lowest bit first with valid/ready.
 */
// Summary of operation
// [R1] Storage is 31 blocks of 8 bytes
// [R2] Write protection is never cleared once set
// [R3] Parameter byte follows command; valid one answers CRC
// [R4] Each block programs at most 8 times
// [R5] Bytes low first, bits low first
// [R6] Sent CRC is the complemented register
// [R7] Command 55h writes a whole block
// [R8] Data held in an 8-byte buffer first
// [R9] Flow continues into following blocks
// [R10] CRC after parameter and after each data block
// [R11] Master resets the bus on bad CRC
// [R12] Programming starts only after release byte
// [R13] Any byte value serves as release
// [R14] Programming time starts after release byte
// [R15] One status byte after programming
// [R16] Success status: remaining count, then A
// [R17] Protected block reports 55h, not programmed
// [R18] Exhausted block reports 33h, not programmed
// [R19] Internal programming failure reports EEh
// [R20] Master resets the bus on failed status
// [R21] First CRC over command and parameter
// [R22] Later Protocol_checksum over the eight new bytes
// [R23] Low five parameter bits give block index
// [R24] Block index above 30 is invalid
// [R25] Invalid parameter: silent until bus reset
// [R26] CRC polynomial x16+x15+x2+1
// [R27] Success decrements counter and advances block
`timescale 1ns/100ps

// ************************************************************
// Transmit FIFO with registered output stage
// ************************************************************
module nvb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_flush,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready = (count != (AW+1)'(DEPTH));
	assign push       = i_in_valid && o_in_ready;
	assign pop        = (count != '0) && (!o_out_valid || i_out_ready);

	always_ff @(posedge i_clk) begin
		if (push) begin
			store[wptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else if (i_flush) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Output register keeps the link-facing outputs straight from flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out_valid <= 1'b0;
			o_out_data  <= '0;
		end else if (i_flush) begin
			o_out_valid <= 1'b0;
		end else if (pop) begin
			o_out_valid <= 1'b1;
			o_out_data  <= store[rptr];
		end else if (i_out_ready) begin
			o_out_valid <= 1'b0;
		end
	end

endmodule : nvb_fifo

// ************************************************************
// Command interpreter
// ************************************************************
module nvb_block_write
	import nvb_pkg::*;
#(
	parameter int PROG_TIME = PROG_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_bus_reset,
	input  wire logic       i_rx_valid,
	input  wire logic [7:0] i_rx_byte,
	output logic            o_tx_valid,
	output logic [7:0]      o_tx_byte,
	input  wire logic       i_tx_ready,
	input  wire logic       i_prog_fail,
	output logic            o_prog_active
);

	// ************************************************************
	// Nonvolatile arrays and working state
	// ************************************************************
	// Arrays model NV cells: power-up values only, untouched by reset
	logic [7:0]  mem       [NUM_BLOCKS][BLOCK_BYTES];  // see [R1]
	logic        protect   [NUM_BLOCKS] = '{default: 1'b0};
	logic [3:0]  remain    [NUM_BLOCKS] = '{default: MAX_WRITES};
	logic [7:0]  wbuf      [BLOCK_BYTES];              // see [R8]

	nvb_state_t  state;
	logic [4:0]  block_index;
	logic [2:0]  byte_cnt;
	logic        tx_hi;
	logic        data_crc;
	logic [15:0] crc;
	logic [7:0]  cs_byte;
	logic [31:0] prog_cnt;
	logic        mem_we;

	logic        push_valid;
	logic [7:0]  push_data;
	logic        push_ready;
	logic        push_fire;
	logic        cs_ok;
	logic        last_crc_byte;
	logic [4:0]  rx_index;

	assign rx_index      = i_rx_byte[4:0];                      // see [R23]
	assign cs_ok         = (cs_byte[3:0] == CS_OK_NIBBLE);
	assign push_fire     = push_valid && push_ready;
	assign last_crc_byte = push_fire && tx_hi;

	// Complemented checksum, low byte first
	always_comb begin
		push_valid = 1'b0;
		push_data  = 8'h00;
		if (state == NVB_CRC_TX) begin
			push_valid = 1'b1;
			push_data  = tx_hi ? ~crc[15:8] : ~crc[7:0];      // see [R5] see [R6]
		end else if (state == NVB_STATUS) begin
			push_valid = 1'b1;
			push_data  = cs_byte;                              // see [R15]
		end
	end

	// ************************************************************
	// Command sequencing
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= NVB_IDLE;
		end else if (i_bus_reset) begin
			state <= NVB_IDLE;
		end else begin
			unique case (state)
				NVB_IDLE: begin
					if (i_rx_valid) begin
						state <= (i_rx_byte == CMD_WRITE_BLOCK) ? NVB_PARAM : NVB_HALT; // see [R7]
					end
				end
				NVB_PARAM: begin
					if (i_rx_valid) begin
						state <= (rx_index <= LAST_BLOCK) ? NVB_CRC_TX : NVB_HALT; // see [R3] see [R24] see [R25]
					end
				end
				NVB_CRC_TX: begin
					if (last_crc_byte) begin
						state <= data_crc ? NVB_RELEASE : NVB_DATA;   // see [R10]
					end
				end
				NVB_DATA: begin
					if (i_rx_valid && byte_cnt == 3'd7) begin
						state <= NVB_CRC_TX;                          // see [R10]
					end
				end
				NVB_RELEASE: begin
					if (i_rx_valid) begin
						state <= NVB_PROG;                            // see [R12] see [R13]
					end
				end
				NVB_PROG: begin
					if (prog_cnt == 32'd0) begin
						state <= NVB_STATUS;
					end
				end
				NVB_STATUS: begin
					if (push_fire) begin
						state <= (cs_ok && block_index != LAST_BLOCK) ? NVB_DATA : NVB_HALT; // see [R9]
					end
				end
				NVB_HALT: begin
					state <= NVB_HALT;
				end
			endcase
		end
	end

	// ************************************************************
	// Block index, byte counters, checksum phase
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			block_index <= 5'h00;
			byte_cnt    <= 3'd0;
			tx_hi       <= 1'b0;
			data_crc    <= 1'b0;
		end else if (i_bus_reset) begin
			byte_cnt <= 3'd0;
			tx_hi    <= 1'b0;
			data_crc <= 1'b0;
		end else begin
			if (state == NVB_PARAM && i_rx_valid) begin
				block_index <= rx_index;
			end
			if (state == NVB_STATUS && push_fire && cs_ok && block_index != LAST_BLOCK) begin
				block_index <= block_index + 5'd1;            // see [R27]
			end
			if (state == NVB_DATA && i_rx_valid) begin
				byte_cnt <= byte_cnt + 3'd1;
			end
			if (push_fire && state == NVB_CRC_TX) begin
				tx_hi <= ~tx_hi;
			end
			if (last_crc_byte) begin
				data_crc <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (state == NVB_DATA && i_rx_valid) begin
			wbuf[byte_cnt] <= i_rx_byte;                       // see [R8]
		end
	end

	// ************************************************************
	// Checksum generator
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc <= CRC_CLEAR;
		end else if (i_rx_valid && state == NVB_IDLE) begin
			crc <= nvb_crc_byte(CRC_CLEAR, i_rx_byte);         // see [R21] see [R26]
		end else if (i_rx_valid && (state == NVB_PARAM || state == NVB_DATA)) begin
			crc <= nvb_crc_byte(crc, i_rx_byte);               // see [R21] see [R22]
		end else if (last_crc_byte || (state == NVB_STATUS && push_fire)) begin
			crc <= CRC_CLEAR;                                  // see [R22]
		end
	end

	// ************************************************************
	// Programming timer and completion status
	// ************************************************************
	// Refused writes skip the timer: nothing is programmed
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prog_cnt      <= 32'd0;
			o_prog_active <= 1'b0;
			cs_byte       <= 8'h00;
		end else if (i_bus_reset) begin
			prog_cnt      <= 32'd0;
			o_prog_active <= 1'b0;
		end else if (state == NVB_RELEASE && i_rx_valid) begin
			if (protect[block_index]) begin
				cs_byte <= CS_PROTECTED;                       // see [R17]
			end else if (remain[block_index] == 4'h0) begin
				cs_byte <= CS_EXHAUSTED;                       // see [R4] see [R18]
			end else begin
				prog_cnt      <= 32'(PROG_TIME - 1);           // see [R14]
				o_prog_active <= 1'b1;
			end
		end else if (state == NVB_PROG) begin
			if (prog_cnt != 32'd0) begin
				prog_cnt <= prog_cnt - 32'd1;
			end else if (o_prog_active) begin
				o_prog_active <= 1'b0;
				if (i_prog_fail) begin
					cs_byte <= CS_FAULT;                       // see [R19]
				end else begin
					cs_byte <= {remain[block_index] - 4'h1, CS_OK_NIBBLE}; // see [R16]
				end
			end
		end
	end

	assign mem_we = (state == NVB_PROG) && (prog_cnt == 32'd0) && o_prog_active && !i_prog_fail;

	// Protection bits have no clearing path at all
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			for (int i = 0; i < BLOCK_BYTES; i++) begin
				mem[block_index][i] <= wbuf[i];                // see [R7]
			end
			remain[block_index] <= remain[block_index] - 4'h1; // see [R27]
		end
	end

	// ************************************************************
	// Transmit path
	// ************************************************************
	nvb_fifo #(
		.WIDTH (8),
		.DEPTH (TX_FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_flush     (i_bus_reset),
		.i_in_valid  (push_valid),
		.i_in_data   (push_data),
		.o_in_ready  (push_ready),
		.o_out_valid (o_tx_valid),
		.o_out_data  (o_tx_byte),
		.i_out_ready (i_tx_ready)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || i_bus_reset);

	logic [3:0] remain_cur;
	logic       prot_cur;
	assign remain_cur = remain[block_index];
	assign prot_cur   = protect[block_index];

	sequence release_seen;
		state == NVB_RELEASE && i_rx_valid;
	endsequence

	sequence prog_entered;
		state == NVB_PROG;
	endsequence

	chk_invalid_index: assert property ( // see [R24]
		state == NVB_PARAM && i_rx_valid && rx_index > LAST_BLOCK |=> state == NVB_HALT)
		else $error("invalid block index not refused");
	// Once drained while halted, the link side must stay quiet
	chk_halt_silent: assert property ( // see [R25]
		state == NVB_HALT && $past(state) == NVB_HALT && !o_tx_valid |=> !o_tx_valid)
		else $error("output while halted");
	chk_release_prog: assert property ( // see [R12]
		release_seen |=> prog_entered)
		else $error("release byte did not start programming");
	chk_data_crc: assert property ( // see [R10]
		state == NVB_DATA && i_rx_valid && byte_cnt == 3'd7 |=> state == NVB_CRC_TX ##0 !tx_hi)
		else $error("no checksum after eighth data byte");
	chk_prog_hold: assert property ( // see [R14]
		state == NVB_PROG && prog_cnt != 32'd0 |=> state == NVB_PROG && $past(prog_cnt) - 32'd1 == prog_cnt)
		else $error("programming interval cut short");
	chk_protect_status: assert property ( // see [R17]
		release_seen ##0 prot_cur |=> prog_entered ##1 cs_byte == CS_PROTECTED)
		else $error("protected block status wrong");
	chk_exhaust_status: assert property ( // see [R18]
		release_seen ##0 !prot_cur && remain_cur == 4'h0 |=> ##1 cs_byte == CS_EXHAUSTED)
		else $error("exhausted block status wrong");
	chk_no_prot_write: assert property ( // see [R17] see [R18]
		mem_we |-> !prot_cur && remain_cur != 4'h0)
		else $error("write into protected or exhausted block");
	chk_remain_dec: assert property ( // see [R27]
		mem_we |=> remain_cur == $past(remain_cur) - 4'h1 && cs_byte == {remain_cur, CS_OK_NIBBLE})
		else $error("write counter or status not updated");
	chk_crc_order: assert property ( // see [R6]
		state == NVB_CRC_TX && push_fire && !tx_hi |-> push_data == ~crc[7:0])
		else $error("checksum low byte not complemented first");

endmodule : nvb_block_write

// ===== test/nvb_link_model.sv
/*
 * Far-side link model for the block-write interpreter: takes transmit bytes
 * with valid/ready and reports each byte it took as a one-cycle strobe.
 * Assumes the same clock and reset as the design, and a bench that sets the pace.
 */
`timescale 1ns/100ps

// ************************************************************
// Byte sink, prompt or slow
// ************************************************************
module nvb_link_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_slow,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	output logic            o_tx_ready,
	output logic            o_got,
	output logic [7:0]      o_got_byte
);
	logic [1:0] phase;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// Slow mode stalls three cycles of four, like a link busy with slots
	assign o_tx_ready = !i_slow || (phase == 2'h3);

	// Whole bytes only; the wire side shifts them lowest bit first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_got      <= 1'b0;
			o_got_byte <= 8'h00;
		end else begin
			o_got      <= i_tx_valid && o_tx_ready;
			o_got_byte <= i_tx_byte;
		end
	end
endmodule : nvb_link_model

// ===== test/nvb_block_write_tb.sv
/*
 * Self-checking bench for the block-write interpreter with a link model.
 * Assumes a short programming time parameter and fresh, unprotected memory.
 */
`timescale 1ns/100ps

// ************************************************************
// Bench top
// ************************************************************
module nvb_block_write_tb;
	import nvb_pkg::*;
	localparam int PT = 8;
	logic       i_clk, i_rst_n, i_bus_reset, i_rx_valid, i_prog_fail;
	logic       i_tx_ready, o_tx_valid, o_prog_active, slow, got;
	logic [7:0] i_rx_byte, o_tx_byte, got_byte;
	logic [7:0] rxq[$];
	int         n_fail, total_checks;
	int         rem[31];

	nvb_block_write #(.PROG_TIME(PT)) nvb_block_write_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_reset(i_bus_reset),
		.i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_tx_valid(o_tx_valid),
		.o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .i_prog_fail(i_prog_fail),
		.o_prog_active(o_prog_active));

	nvb_link_model nvb_link_model_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow), .i_tx_valid(o_tx_valid),
		.i_tx_byte(o_tx_byte), .o_tx_ready(i_tx_ready), .o_got(got), .o_got_byte(got_byte));

	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		if (got) begin
			rxq.push_back(got_byte);
		end
	end

	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction : crc_add

	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic send(input logic [7:0] b);
		@(posedge i_clk);
		i_rx_valid <= 1'b1;
		i_rx_byte  <= b;
		@(posedge i_clk);
		i_rx_valid <= 1'b0;
	endtask : send

	// Bytes still queued from an abandoned flow are dropped
	task automatic bus_rst();
		@(posedge i_clk);
		i_bus_reset <= 1'b1;
		@(posedge i_clk);
		i_bus_reset <= 1'b0;
		repeat (4) @(posedge i_clk);
		rxq.delete();
	endtask : bus_rst

	task automatic take(input int n, output logic [15:0] v);
		int t;
		t = 0;
		v = 16'h0000;
		while (rxq.size() < n && t < 400) begin
			@(posedge i_clk);
			t++;
		end
		if (rxq.size() < n) begin
			v = 'x;
		end else begin
			for (int i = 0; i < n; i++) begin
				v[8*i+:8] = rxq.pop_front();
			end
		end
	endtask : take

	task automatic silent(input string name);
		repeat (40) @(posedge i_clk);
		check(name, 16'(rxq.size()), 16'h0000);
	endtask : silent

	// Refused command or index: nothing may come back before a bus reset
	task automatic refused(input string name, input logic [7:0] cmd, input logic [7:0] prm);
		bus_rst();
		send(cmd);
		send(prm);
		for (int k = 0; k < 9; k++) begin
			send(8'(k));
		end
		silent(name);
	endtask : refused

	// Checksum judged bad: the flow is dropped and nothing gets programmed
	task automatic abandon();
		logic [15:0] v;
		bus_rst();
		send(CMD_WRITE_BLOCK);
		send(8'h04);
		take(2, v);
		check("crc_abandon", v, ~crc_add(crc_add(16'h0000, 8'h55), 8'h04));
		bus_rst();
		for (int k = 0; k < 9; k++) begin
			send(8'(k));
		end
		check("abandon_prog", {15'h0000, o_prog_active}, 16'h0000);
		silent("abandon");
	endtask : abandon

	// One block: optional command phase, data, release, status
	task automatic wr(input logic [4:0] blk, input logic [7:0] prm, input bit first,
			input logic [7:0] rel, input bit fail);
		logic [15:0] c, v;
		logic [7:0]  st;
		int          n;
		if (first) begin
			send(CMD_WRITE_BLOCK);
			send(prm);
			take(2, v);
			check("crc_param", v, ~crc_add(crc_add(16'h0000, 8'h55), prm));
		end
		c = 16'h0000;
		for (int k = 0; k < 8; k++) begin
			send(rel ^ {blk, 3'(k)});
			c = crc_add(c, rel ^ {blk, 3'(k)});
		end
		take(2, v);
		check("crc_data", v, ~c);
		check("prog_early", {15'h0000, o_prog_active}, 16'h0000);
		i_prog_fail <= fail;
		send(rel);
		n = 0;
		// Sampled mid-cycle, clear of the edge that launches the flag
		repeat (PT + 12) begin
			@(negedge i_clk);
			if (o_prog_active === 1'b1) begin
				n++;
			end
		end
		@(posedge i_clk);
		i_prog_fail <= 1'b0;
		if (rem[blk] == 0) begin
			st = CS_EXHAUSTED;
		end else if (fail) begin
			st = CS_FAULT;
		end else begin
			rem[blk]--;
			st = {4'(rem[blk]), CS_OK_NIBBLE};
		end
		check("prog_len", 16'(n), (st == CS_EXHAUSTED) ? 16'h0000 : 16'(PT));
		take(1, v);
		check("status", v, {8'h00, st});
	endtask : wr

	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		stop_test();
	end

	initial begin
		i_clk        = 1'b0;
		i_rst_n      = 1'b0;
		i_bus_reset  = 1'b0;
		i_rx_valid   = 1'b0;
		i_rx_byte    = 8'h00;
		i_prog_fail  = 1'b0;
		slow         = 1'b0;
		n_fail       = 0;
		total_checks = 0;
		foreach (rem[b]) begin
			rem[b] = 8;
		end
		repeat (6) @(posedge i_clk);
		check("rst_out", {14'h0000, o_tx_valid, o_prog_active}, 16'h0000);
		i_rst_n <= 1'b1;
		wr(5'd0, 8'hE0, 1, 8'h00, 0);
		slow <= 1'b1;
		wr(5'd1, 8'h00, 0, 8'hA5, 0);
		slow <= 1'b0;
		// Wear one block down past its last allowed write
		for (int i = 0; i < 9; i++) begin
			bus_rst();
			wr(5'd2, {3'(i), 5'd2}, 1, 8'(i * 37), 0);
		end
		bus_rst();
		wr(5'd3, 8'h03, 1, 8'hFF, 1);
		bus_rst();
		wr(5'd3, 8'h03, 1, 8'h3C, 0);
		bus_rst();
		wr(5'd30, 8'h1E, 1, 8'h5A, 0);
		refused("bad_index", CMD_WRITE_BLOCK, 8'hFF);
		refused("bad_cmd", 8'h33, 8'h00);
		abandon();
		// Full count still left: the abandoned flow programmed nothing
		bus_rst();
		wr(5'd4, 8'h04, 1, 8'h11, 0);
		stop_test();
	end
endmodule : nvb_block_write_tb
